//--- hw/rcp_cmd_port.sv
// Notes on behaviour
// - strap sampled in reset: high slow, low fast
// - 8 data bits, no parity, one stop
// - collect all data bytes before executing
// - short command leaves port waiting, no recovery
// - query answer always five bytes long
// - address byte then data, 2 to 6 total
// - at least one data byte per command
// - answer byte 4 first, down to 0
`timescale 1ns/1ps
`default_nettype none
module rcp_cmd_port
    import rcp_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        baud_strap,    // pin, low selects fast rate
    input  wire logic        rxd,           // serial in, from pin
    output logic             txd,           // serial out
    output logic [7:0]       cmd_addr_o,    // register address of command
    input  wire logic [2:0]  cmd_len_i,     // data bytes for cmd_addr_o
    input  wire logic        cmd_query_i,   // cmd_addr_o is a query register
    output logic             cmd_valid_o,   // one-cycle, command complete
    output logic [39:0]      cmd_data_o,    // data bytes, last in [7:0]
    output logic [2:0]       cmd_count_o,   // data bytes held
    output logic             resp_pend_o,   // waiting for answer word
    input  wire logic        resp_load_i,   // one-cycle, answer word valid
    input  wire logic [39:0] resp_data_i    // answer, byte 4 in [39:32]
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] rx_sync_q;     // three-stage chain on rxd
    logic [2:0] strap_sync_q;  // three-stage chain on strap
    logic       rx_f_q;        // filtered line level
    logic       strap_f_q;     // filtered strap level
    logic       baud_fast_q;   // rate chosen at reset
    logic [9:0] div;           // active bit period

    // no reset on the chains so the strap is seen while resetn is low
    always_ff @(posedge mclk) begin
        rx_sync_q    <= {rx_sync_q[1:0], rxd};
        strap_sync_q <= {strap_sync_q[1:0], baud_strap};
    end

    // a change counts once stages two and three agree
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rx_f_q <= 1'b1;
        end else if (rx_sync_q[1] == rx_sync_q[2]) begin
            rx_f_q <= rx_sync_q[2];
        end
    end

    always_ff @(posedge mclk) begin
        if (strap_sync_q[1] == strap_sync_q[2]) begin
            strap_f_q <= strap_sync_q[2];
        end
    end

    // rate latched only while reset is held, frozen after release
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            baud_fast_q <= ~strap_f_q;
        end
    end

    assign div = baud_fast_q ? DIV_FAST : DIV_SLOW;

    // ------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------
    rcp_rx_t    rx_st_q;     // receive state
    logic [9:0] rx_cnt_q;    // cycles to next sample point
    logic [2:0] rx_bit_q;    // data bit index
    logic [7:0] rx_sh_q;     // assembled character
    logic       rx_valid_q;  // one-cycle, good character

    // mid-bit sampling; a start glitch or bad stop is dropped silently
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rx_st_q    <= RX_IDLE;
            rx_cnt_q   <= RST_CNT;
            rx_bit_q   <= 3'h0;
            rx_sh_q    <= RST_BYTE;
            rx_valid_q <= 1'b0;
        end else begin
            rx_valid_q <= 1'b0;
            case (rx_st_q)
                RX_IDLE: begin
                    // low line level opens a character
                    if (!rx_f_q) begin
                        rx_st_q  <= RX_START;
                        rx_cnt_q <= div >> 1;
                    end
                end
                RX_START: begin
                    if (rx_cnt_q == RST_CNT) begin
                        rx_bit_q <= 3'h0;
                        rx_cnt_q <= div - 10'h001;
                        rx_st_q  <= rx_f_q ? RX_IDLE : RX_BITS;
                    end else begin
                        rx_cnt_q <= rx_cnt_q - 10'h001;
                    end
                end
                RX_BITS: begin
                    if (rx_cnt_q == RST_CNT) begin
                        rx_sh_q  <= {rx_f_q, rx_sh_q[7:1]};   // lsb first
                        rx_cnt_q <= div - 10'h001;
                        if (rx_bit_q == DATA_BITS_M1) begin
                            rx_st_q <= RX_STOP;
                        end else begin
                            rx_bit_q <= rx_bit_q + 3'h1;
                        end
                    end else begin
                        rx_cnt_q <= rx_cnt_q - 10'h001;
                    end
                end
                RX_STOP: begin
                    // no parity bit; stop must read high
                    if (rx_cnt_q == RST_CNT) begin
                        rx_st_q    <= RX_IDLE;
                        rx_valid_q <= rx_f_q;
                    end else begin
                        rx_cnt_q <= rx_cnt_q - 10'h001;
                    end
                end
                default: rx_st_q <= RX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // command assembly
    // ------------------------------------------------------------
    rcp_cmd_t   cm_st_q;   // command state
    logic [2:0] len_q;     // data bytes expected
    logic [2:0] got_q;     // data bytes received
    logic       query_q;   // command is a query

    // no timeout: a short command keeps waiting until reset
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cm_st_q     <= CM_IDLE;
            cmd_addr_o  <= RST_BYTE;
            cmd_data_o  <= RST_WORD;
            cmd_count_o <= 3'h0;
            cmd_valid_o <= 1'b0;
            len_q       <= MIN_DATA;
            got_q       <= 3'h0;
            query_q     <= 1'b0;
        end else begin
            cmd_valid_o <= 1'b0;
            case (cm_st_q)
                CM_IDLE: begin
                    // first byte is always the address
                    if (rx_valid_q) begin
                        cmd_addr_o <= rx_sh_q;
                        cm_st_q    <= CM_LEN;
                    end
                end
                CM_LEN: begin
                    // length clamped into 1..5 data bytes
                    if (cmd_len_i < MIN_DATA) begin
                        len_q <= MIN_DATA;
                    end else if (cmd_len_i > MAX_DATA) begin
                        len_q <= MAX_DATA;
                    end else begin
                        len_q <= cmd_len_i;
                    end
                    query_q    <= cmd_query_i;
                    got_q      <= 3'h0;
                    cmd_data_o <= RST_WORD;
                    cm_st_q    <= CM_DATA;
                end
                CM_DATA: begin
                    if (rx_valid_q) begin
                        cmd_data_o <= {cmd_data_o[31:0], rx_sh_q};
                        got_q      <= got_q + 3'h1;
                        if (got_q + 3'h1 == len_q) begin
                            cm_st_q <= CM_DONE;
                        end
                    end
                end
                CM_DONE: begin
                    cmd_valid_o <= 1'b1;
                    cmd_count_o <= got_q;
                    cm_st_q     <= CM_IDLE;
                end
                default: cm_st_q <= CM_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // query answer
    // ------------------------------------------------------------
    logic [39:0] resp_sh_q;    // answer, next byte on top
    logic [2:0]  resp_left_q;  // bytes still to send
    logic        tx_start_q;   // one-cycle send request
    logic [7:0]  tx_byte_q;    // byte handed to sender
    logic        tx_busy;      // sender occupied
    logic        resp_take;    // answer word taken this edge

    // take a word only with the sender fully idle, so byte 4 leaves next;
    // a word offered while the last byte is still on the line is ignored
    assign resp_take = resp_pend_o && resp_load_i && resp_left_q == 3'h0
                       && !tx_busy && !tx_start_q;

    // pending set on a finished query; load accepted once sender idle
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            resp_pend_o <= 1'b0;
        end else if (cm_st_q == CM_DONE && query_q) begin
            resp_pend_o <= 1'b1;                        // set wins
        end else if (resp_take) begin
            resp_pend_o <= 1'b0;
        end
    end

    // five bytes, most significant first
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            resp_sh_q   <= RST_WORD;
            resp_left_q <= 3'h0;
            tx_start_q  <= 1'b0;
            tx_byte_q   <= RST_BYTE;
        end else begin
            tx_start_q <= 1'b0;
            if (resp_take) begin
                resp_sh_q   <= resp_data_i;
                resp_left_q <= RESP_BYTES;
            end else if (resp_left_q != 3'h0 && !tx_busy && !tx_start_q) begin
                tx_start_q  <= 1'b1;
                tx_byte_q   <= resp_sh_q[39:32];
                resp_sh_q   <= {resp_sh_q[31:0], RST_BYTE};
                resp_left_q <= resp_left_q - 3'h1;
            end
        end
    end

    rcp_uart_tx u_tx (
        .mclk    (mclk),
        .resetn  (resetn),
        .div_i   (div),
        .start_i (tx_start_q),
        .byte_i  (tx_byte_q),
        .txd_o   (txd),
        .busy_o  (tx_busy)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    baud_frozen_a: assert property (@(posedge mclk) disable iff (!resetn)
        $stable(baud_fast_q))
        else $error("rate changed outside reset");
    cmd_full_count_a: assert property (@(posedge mclk) disable iff (!resetn)
        cmd_valid_o |-> cmd_count_o == len_q)
        else $error("command issued with missing bytes");
    cmd_wait_data_a: assert property (@(posedge mclk) disable iff (!resetn)
        cm_st_q == CM_DATA && !rx_valid_q |=> cm_st_q == CM_DATA)
        else $error("command left before its bytes");
    cmd_len_range_a: assert property (@(posedge mclk) disable iff (!resetn)
        cm_st_q == CM_DATA |-> len_q >= MIN_DATA && len_q <= MAX_DATA)
        else $error("data length outside one to five");
    rx_stop_good_a: assert property (@(posedge mclk) disable iff (!resetn)
        rx_valid_q |-> $past(rx_st_q) == RX_STOP && $past(rx_f_q))
        else $error("character accepted without stop");
    resp_five_a: assert property (@(posedge mclk) disable iff (!resetn)
        resp_take |=> resp_left_q == RESP_BYTES)
        else $error("answer length not five");
    resp_msb_first_a: assert property (@(posedge mclk) disable iff (!resetn)
        resp_take
        |=> ##1 tx_start_q && tx_byte_q == $past(resp_data_i[39:32], 2))
        else $error("answer did not open with byte 4");
    cmd_done_cov: cover property (@(posedge mclk) disable iff (!resetn) cmd_valid_o);
    query_done_cov: cover property (@(posedge mclk) disable iff (!resetn)
        $fell(tx_busy) && resp_left_q == 3'h0);
    fast_rate_cov: cover property (@(posedge mclk) disable iff (!resetn)
        baud_fast_q && rx_valid_q);
endmodule : rcp_cmd_port
`default_nettype wire

//--- hw/rcp_pkg.sv
`default_nettype none
package rcp_pkg;
    // ------------------------------------------------------------
    // clock and line rates
    // ------------------------------------------------------------
    localparam int CLK_HZ    = 50_000_000;   // mclk rate
    localparam int BAUD_SLOW = 56700;        // strap high or open
    localparam int BAUD_FAST = 115200;       // strap held low
    // bit periods in mclk cycles, rounded to nearest
    localparam logic [9:0] DIV_SLOW = 10'((CLK_HZ + BAUD_SLOW / 2) / BAUD_SLOW);
    localparam logic [9:0] DIV_FAST = 10'((CLK_HZ + BAUD_FAST / 2) / BAUD_FAST);

    // ------------------------------------------------------------
    // character and command framing
    // ------------------------------------------------------------
    localparam logic [2:0] DATA_BITS_M1 = 3'h7;  // 8 data bits
    localparam logic [3:0] STOP_IDX     = 4'h9;  // start + 8 data, then stop
    localparam logic [2:0] MIN_DATA     = 3'h1;  // least data bytes per command
    localparam logic [2:0] MAX_DATA     = 3'h5;  // most data bytes per command
    localparam logic [2:0] RESP_BYTES   = 3'h5;  // fixed query answer length

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [39:0] RST_WORD = 40'h00_0000_0000;
    localparam logic [9:0]  RST_CNT  = 10'h000;

    // receiver and command states, gray along the usual path
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_BITS  = 2'b11,
        RX_STOP  = 2'b10
    } rcp_rx_t;

    typedef enum logic [1:0] {
        CM_IDLE = 2'b00,
        CM_LEN  = 2'b01,
        CM_DATA = 2'b11,
        CM_DONE = 2'b10
    } rcp_cmd_t;
endpackage : rcp_pkg
`default_nettype wire

//--- hw/rcp_uart_tx.sv
`timescale 1ns/1ps
`default_nettype none
module rcp_uart_tx
    import rcp_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic [9:0] div_i,     // bit period in cycles
    input  wire logic       start_i,   // one-cycle request
    input  wire logic [7:0] byte_i,    // character to send
    output logic            txd_o,     // serial line, idles high
    output logic            busy_o     // character in flight
);
    // ------------------------------------------------------------
    // framing state
    // ------------------------------------------------------------
    logic [9:0] frame_q;   // stop, data lsb first, start
    logic [9:0] cnt_q;     // cycles left in current bit
    logic [3:0] idx_q;     // bit being sent, 0 = start

    // shift one character out, start bit low, stop bit high
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            frame_q <= RST_CNT;
            cnt_q   <= RST_CNT;
            idx_q   <= 4'h0;
            txd_o   <= 1'b1;
            busy_o  <= 1'b0;
        end else if (start_i && !busy_o) begin
            frame_q <= {1'b1, byte_i, 1'b0};
            busy_o  <= 1'b1;
            cnt_q   <= div_i - 10'h001;
            idx_q   <= 4'h0;
            txd_o   <= 1'b0;
        end else if (busy_o) begin
            if (cnt_q == RST_CNT) begin
                if (idx_q == STOP_IDX) begin
                    busy_o <= 1'b0;                     // single stop bit
                end else begin
                    idx_q   <= idx_q + 4'h1;
                    frame_q <= {1'b1, frame_q[9:1]};
                    txd_o   <= frame_q[1];
                    cnt_q   <= div_i - 10'h001;
                end
            end else begin
                cnt_q <= cnt_q - 10'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    tx_start_bit_a: assert property (@(posedge mclk) disable iff (!resetn)
        start_i && !busy_o |=> !txd_o && busy_o)
        else $error("start bit not driven low");
    tx_stop_level_a: assert property (@(posedge mclk) disable iff (!resetn)
        $fell(busy_o) |-> txd_o && $past(txd_o))
        else $error("character did not end on stop level");
    tx_idle_high_a: assert property (@(posedge mclk) disable iff (!resetn)
        !busy_o && !$past(busy_o) |-> txd_o)
        else $error("line not idle high");
    tx_char_cov: cover property (@(posedge mclk) disable iff (!resetn) $fell(busy_o));
endmodule : rcp_uart_tx
`default_nettype wire

//--- verification/rcp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------------------------------
// host computer model: plain 8N1 serial port, no flow control
// --------------------------------------------------------------------
module rcp_host_model
    import rcp_pkg::*;
(
    input  wire logic mclk,
    output logic      host_txd,  // drives the port's receive pin
    input  wire logic host_rxd   // watches the port's transmit pin
);
    // line idles high between characters
    initial host_txd = 1'b1;

    // one character after gap idle cycles; start low, lsb first, one stop
    // the caller sends address then every data byte, zeros too
    task automatic send_byte(input logic [7:0] b, input int div, input int gap);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        repeat (gap) @(posedge mclk);
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk);
            host_txd <= frame[i];
            repeat (div - 1) @(posedge mclk);
        end
    endtask : send_byte

    // receive one character, sampled mid bit; framed low if start or stop wrong
    task automatic recv_byte(input int div, output logic [7:0] b, output logic framed);
        int wait_n;
        wait_n = 0;
        // bounded wait so a silent port cannot hang the run
        while (host_rxd !== 1'b0 && wait_n < 4 * div) begin
            @(posedge mclk);
            wait_n++;
        end
        repeat (div / 2) @(posedge mclk);
        framed = (host_rxd === 1'b0);
        for (int i = 0; i < 8; i++) begin
            repeat (div) @(posedge mclk);
            b[i] = host_rxd;
        end
        repeat (div) @(posedge mclk);
        framed = framed && (host_rxd === 1'b1);
    endtask : recv_byte
endmodule : rcp_host_model
`default_nettype wire

//--- verification/tb_rs232_register_command_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rs232_register_command_port
    import rcp_pkg::*;
;
    // ----------------------------------------------------------------
    // stimulus rows and signals
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  addr;   // register address byte
        logic [2:0]  len;    // data bytes that follow
        logic        query;  // answer expected
        logic [39:0] data;   // data bytes, last sent in [7:0]
        logic [39:0] resp;   // answer word from core
    } rcp_row_t;

    localparam int LIMIT = 100000;  // cycle ceiling for the whole run

    logic        mclk;
    logic        resetn;
    logic        baud_strap;
    logic        rxd;
    logic        txd;
    logic [7:0]  cmd_addr;
    logic [2:0]  cmd_len;
    logic        cmd_query;
    logic        cmd_valid;
    logic [39:0] cmd_data;
    logic [2:0]  cmd_count;
    logic        resp_pend;
    logic        resp_load;
    logic [39:0] resp_data;
    logic [7:0]  cap_addr;    // captured at the valid pulse
    logic [39:0] cap_data;
    logic [2:0]  cap_cnt;
    int          valid_seen;  // count of valid pulses
    int          cycles;
    int          fail_count;
    int          tests_run;
    rcp_row_t    rows [2];

    // ----------------------------------------------------------------
    // design, host and clock
    // ----------------------------------------------------------------
    rcp_cmd_port i_dut (
        .mclk(mclk), .resetn(resetn), .baud_strap(baud_strap), .rxd(rxd), .txd(txd),
        .cmd_addr_o(cmd_addr), .cmd_len_i(cmd_len), .cmd_query_i(cmd_query),
        .cmd_valid_o(cmd_valid), .cmd_data_o(cmd_data), .cmd_count_o(cmd_count),
        .resp_pend_o(resp_pend), .resp_load_i(resp_load), .resp_data_i(resp_data)
    );

    rcp_host_model i_host (.mclk(mclk), .host_txd(rxd), .host_rxd(txd));

    initial mclk = 1'b0;
    always #10 mclk = ~mclk;

    // capture the command outputs during their one-cycle pulse
    always @(posedge mclk) begin
        if (cmd_valid === 1'b1) begin
            valid_seen <= valid_seen + 1;
            cap_addr   <= cmd_addr;
            cap_data   <= cmd_data;
            cap_cnt    <= cmd_count;
        end
    end

    // hang guard: ceiling counts as a mismatch
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fail_count++;
            conclude();
        end
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [39:0] seen, input logic [39:0] expct);
        tests_run++;
        if (seen !== expct) begin
            fail_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, expct);
        end
    endtask : check

    task automatic conclude();
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    // reset with strap held; outputs checked idle once, after eight reset cycles
    task automatic do_reset(input logic strap);
        baud_strap <= strap;
        resetn     <= 1'b0;
        repeat (8) @(posedge mclk);
        check(40'(txd), 40'h1);
        check(40'({cmd_valid, resp_pend, cmd_count}), 40'h0);
        check(cmd_data, 40'h0);
        check(40'(cmd_addr), 40'h0);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask : do_reset

    // count low samples of txd; the answer must not start unasked
    task automatic watch_idle(input int n);
        int lows;
        lows = 0;
        repeat (n) begin
            @(posedge mclk);
            if (txd !== 1'b1) lows++;
        end
        check(40'(lows), 40'h0);
    endtask : watch_idle

    // one full command, then the answer when it is a query
    task automatic run_row(input rcp_row_t row, input int div);
        int          base;
        logic [7:0]  b;
        logic        ok;
        logic [39:0] expw;
        cmd_len   <= row.len;
        cmd_query <= row.query;
        base = valid_seen;
        i_host.send_byte(row.addr, div, 5);
        for (int k = int'(row.len) - 1; k >= 0; k--) begin
            i_host.send_byte(row.data[8*k +: 8], div, 0);
            check(40'(valid_seen - base), (k == 0) ? 40'h1 : 40'h0);
        end
        expw = row.data & ((40'h1 << (8 * row.len)) - 40'h1);
        check(40'(cap_addr), 40'(row.addr));
        check(40'(cap_cnt), 40'(row.len));
        check(cap_data, expw);
        check(40'(resp_pend), 40'(row.query));
        if (row.query) begin
            resp_data <= row.resp;
            resp_load <= 1'b1;
            @(posedge mclk);
            resp_load <= 1'b0;
            for (int k = 4; k >= 0; k--) begin
                i_host.recv_byte(div, b, ok);
                check(40'(b), 40'(row.resp[8*k +: 8]));
                check(40'(ok), 40'h1);
            end
            check(40'(resp_pend), 40'h0);
            watch_idle(2 * div);
        end
    endtask : run_row

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        resetn     = 1'b0;
        baud_strap = 1'b0;
        cmd_len    = 3'h1;
        cmd_query  = 1'b0;
        resp_load  = 1'b0;
        resp_data  = 40'h00_0000_0000;
        valid_seen = 0;
        cycles     = 0;
        fail_count = 0;
        tests_run  = 0;
        // longest write, then a query whose one data byte is zero
        rows[0] = '{8'h10, 3'h5, 1'b0, 40'hA1_B2_C3_D4_E5, 40'h00_0000_0000};
        rows[1] = '{8'h26, 3'h1, 1'b1, 40'h00_0000_0000, 40'h81_42_C3_24_A5};
        do_reset(1'b0);
        // answer load with nothing pending is ignored
        resp_data <= 40'hFF_FF_FF_FF_00;
        resp_load <= 1'b1;
        @(posedge mclk);
        resp_load <= 1'b0;
        watch_idle(40);
        for (int r = 0; r < 2; r++) begin
            run_row(rows[r], int'(DIV_FAST));
        end
        // zero length from the core is taken as one data byte
        cmd_len <= 3'h0;
        begin : zero_len
            int base;
            base = valid_seen;
            i_host.send_byte(8'h33, int'(DIV_FAST), 5);
            i_host.send_byte(8'h7E, int'(DIV_FAST), 0);
            check(40'(valid_seen - base), 40'h1);
            check(40'(cap_addr), 40'h33);
            check(40'(cap_cnt), 40'h1);
            check(cap_data, 40'h00_0000_007E);
        end
        // short command: length above five taken as five, port keeps waiting
        cmd_len <= 3'h7;
        begin : short_cmd
            int base;
            base = valid_seen;
            i_host.send_byte(8'h0C, int'(DIV_FAST), 5);
            i_host.send_byte(8'h5A, int'(DIV_FAST), 0);
            repeat (4 * int'(DIV_FAST)) @(posedge mclk);
            check(40'(valid_seen - base), 40'h0);
        end
        // mid-run reset with strap high selects the slow rate
        do_reset(1'b1);
        run_row('{8'h05, 3'h1, 1'b0, 40'h00_0000_003C, 40'h00_0000_0000}, int'(DIV_SLOW));
        conclude();
    end
endmodule : tb_rs232_register_command_port
`default_nettype wire
